// ==== srwd_pkg.sv ====
// Constants, register map and state type of the system reset and watchdog block
package srwd_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CAUSE = 8'h00;
	localparam logic [7:0] ADDR_OPT_ONE = 8'h04;
	localparam logic [7:0] ADDR_OPT_TWO = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0C;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int CAUSE_WIDTH = 6;
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_VOLT = 1;
	localparam int CAUSE_WDOG = 2;
	localparam int CAUSE_OPCODE = 3;
	localparam int CAUSE_PIN = 4;
	localparam int CAUSE_CLOCK = 5;
	localparam logic [5:0] CAUSE_RESET = 6'h01;
	localparam int OPT1_TSEL_LSB = 0;
	localparam int OPT_LOCK_BIT = 8;
	localparam int OPT2_CLKSEL_BIT = 0;
	localparam int OPT2_WINDOW_BIT = 1;
	localparam logic [1:0] TSEL_RESET = 2'h3;
	localparam logic CLKSEL_RESET = 1'b1;
	localparam logic WINDOW_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Service bytes, CPU start values, watchdog timing
	// ----------------------------------------------------------------
	localparam logic [7:0] SERVICE_FIRST = 8'h55;
	localparam logic [7:0] SERVICE_SECOND = 8'hAA;
	localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFE;
	localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFF;
	localparam logic [15:0] STACK_POINTER_INIT = 16'h00FF;
	localparam int COUNT_WIDTH = 19;
	localparam logic [18:0] OSC_TIMEOUT_1 = 19'h00020;
	localparam logic [18:0] OSC_TIMEOUT_2 = 19'h00100;
	localparam logic [18:0] OSC_TIMEOUT_3 = 19'h00400;
	localparam int RESET_HOLD_DEFAULT = 16;

	// Reset and start-up sequence
	typedef enum logic [2:0] {
		ST_RESET,
		ST_VEC_HI,
		ST_VEC_LO,
		ST_VEC_END,
		ST_RUN
	} srwd_state_type;

endpackage

// ==== srwd_top.sv ====
// System reset control and service-sequence watchdog with an AHB-Lite register slave
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// RQ1 - After any reset, fetch the program counter from addresses 0xFFFE and 0xFFFF.
// RQ2 - Reset presents stack pointer start value 0x00FF to the processor.
// RQ3 - During reset peripherals are off, pins are inputs, pullups are off.
// RQ4 - Reset sets the interrupt mask bit, blocking maskable interrupts.
// RQ5 - Six of seven reset sources have their own cause bit.
// RQ6 - Watchdog is enabled after reset; timeout select zero disables it.
// RQ7 - Writing 0x55 then 0xAA to the cause address restarts the timeout.
// RQ8 - Writes to the cause address never change the cause bits.
// RQ9 - Any other byte written to the cause address resets at once.
// RQ10 - Timeout expiry without service causes a system reset.
// RQ11 - Clock select picks bus clock or 1 kHz low-power oscillator.
// RQ12 - Three timeout lengths exist for each watchdog clock source.
// RQ13 - Default is the low-power oscillator with 2^10 cycle timeout.
// RQ14 - In bus clock window mode, service only in last quarter.
// RQ15 - An early service write in window mode resets at once.
// RQ16 - Window enable is ignored while the low-power oscillator is chosen.
// RQ17 - Option registers are write-once; first write locks and clears counter.
// RQ18 - Software must write both option registers during start-up.
// RQ19 - Bus clock mode holds the count in debug or stop mode.
// RQ20 - Oscillator mode clears the count in debug or stop mode.
// RQ21 - Software should not service the watchdog from an interrupt routine.
// RQ22 - Each reset leaves only the cause bits of its currently active sources set.
module srwd_top #(
	parameter int unsigned BUS_TIMEOUT_1 = 8192,
	parameter int unsigned BUS_TIMEOUT_2 = 65536,
	parameter int unsigned BUS_TIMEOUT_3 = 262144,
	parameter int unsigned RESET_HOLD = srwd_pkg::RESET_HOLD_DEFAULT,
	parameter int unsigned PIN_COUNT = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic low_voltage_detect,
	input wire logic illegal_opcode_detect,
	input wire logic ext_reset_pin_n,
	input wire logic clock_loss_reset,
	input wire logic debug_force_reset,
	input wire logic low_power_oscillator,
	input wire logic debug_mode,
	input wire logic stop_mode,
	output logic [15:0] vec_addr,
	output logic vec_rd,
	input wire logic [7:0] vec_data,
	output logic [15:0] pc_init,
	output logic cpu_run,
	output logic [15:0] stack_pointer_init,
	output logic irq_mask_set,
	output logic periph_enable,
	input wire logic [PIN_COUNT-1:0] port_out_en_req,
	input wire logic [PIN_COUNT-1:0] port_pullup_req,
	output logic [PIN_COUNT-1:0] pin_out_en,
	output logic [PIN_COUNT-1:0] pin_pullup_en,
	output logic [srwd_pkg::CAUSE_WIDTH-1:0] reset_cause
);
	import srwd_pkg::*;

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	// The counter cannot serve a timeout above its range or below a quarter step
	if (BUS_TIMEOUT_3 > (1 << (COUNT_WIDTH - 1)) || BUS_TIMEOUT_1 < 4 || BUS_TIMEOUT_2 < 4) begin
		$error("srwd_top: bus timeout out of range");
	end
	if (RESET_HOLD < 1 || RESET_HOLD > 65535 || PIN_COUNT < 1) begin
		$error("srwd_top: bad reset hold or pin count");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	srwd_state_type state_reg;
	logic [15:0] hold_cnt_reg;
	logic [15:0] vec_addr_reg;
	logic [15:0] pc_init_reg;
	logic [CAUSE_WIDTH-1:0] cause_reg;
	logic [4:0] src_meta_reg;
	logic [4:0] src_sync_reg;
	logic [1:0] osc_meta_reg;
	logic osc_last_reg;
	logic ph_wr_reg;
	logic [7:0] ph_addr_reg;
	logic [31:0] hrdata_reg;
	logic [1:0] tsel_reg;
	logic clksel_reg;
	logic win_reg;
	logic lock1_reg;
	logic lock2_reg;
	logic armed_reg;
	logic [COUNT_WIDTH-1:0] wd_count_reg;
	logic [COUNT_WIDTH-1:0] wd_limit_now;
	logic [COUNT_WIDTH-1:0] window_open;
	logic [CAUSE_WIDTH-1:0] req_vec;
	logic in_reset;
	logic any_req;
	logic accept;
	logic wr_cause;
	logic wr_opt1;
	logic wr_opt2;
	logic bad_byte;
	logic early;
	logic service_done;
	logic wd_enabled;
	logic window_active;
	logic halt;
	logic osc_edge;
	logic tick;
	logic wd_expire;
	logic cfg_first;

	// Timeout length for a select code and clock source; zero means disabled
	function automatic logic [COUNT_WIDTH-1:0] wd_limit(input logic [1:0] tsel, input logic osc);
		logic [COUNT_WIDTH-1:0] res;
		res = '0;
		unique case (tsel)
			2'h0: res = '0;
			2'h1: res = osc ? OSC_TIMEOUT_1 : COUNT_WIDTH'(BUS_TIMEOUT_1); // RQ12
			2'h2: res = osc ? OSC_TIMEOUT_2 : COUNT_WIDTH'(BUS_TIMEOUT_2); // RQ12
			2'h3: res = osc ? OSC_TIMEOUT_3 : COUNT_WIDTH'(BUS_TIMEOUT_3); // RQ12
		endcase
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Reset sources and the oscillator arrive from pins or other domains
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_meta_reg <= 5'h00;
			src_sync_reg <= 5'h00;
			osc_meta_reg <= 2'h0;
			osc_last_reg <= 1'b0;
		end else begin
			src_meta_reg <= {debug_force_reset, clock_loss_reset, ~ext_reset_pin_n,
				illegal_opcode_detect, low_voltage_detect};
			src_sync_reg <= src_meta_reg;
			osc_meta_reg <= {osc_meta_reg[0], low_power_oscillator};
			osc_last_reg <= osc_meta_reg[1];
		end
	end

	// Rising edge of the oscillator, looked at only past the second flop
	assign osc_edge = osc_meta_reg[1] & ~osc_last_reg;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign accept = hsel & htrans[1] & hready;
	assign wr_cause = ph_wr_reg & (ph_addr_reg == ADDR_CAUSE);
	assign wr_opt1 = ph_wr_reg & (ph_addr_reg == ADDR_OPT_ONE);
	assign wr_opt2 = ph_wr_reg & (ph_addr_reg == ADDR_OPT_TWO);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Address phase capture; the write takes effect in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_reg <= 1'b0;
			ph_addr_reg <= 8'h00;
		end else if (hready) begin
			ph_wr_reg <= accept & hwrite;
			ph_addr_reg <= {haddr[7:2], 2'h0};
		end
	end

	// Read data is latched at the address phase so the data phase sees a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (accept && !hwrite) begin
			unique case ({haddr[7:2], 2'h0})
				ADDR_CAUSE: hrdata_reg <= {26'h0, cause_reg};
				ADDR_OPT_ONE: hrdata_reg <= {23'h0, lock1_reg, 6'h0, tsel_reg};
				ADDR_OPT_TWO: hrdata_reg <= {23'h0, lock2_reg, 6'h0, win_reg, clksel_reg};
				ADDR_COUNT: hrdata_reg <= {13'h0, wd_count_reg};
				default: hrdata_reg <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Watchdog service and reset requests
	// ----------------------------------------------------------------
	assign wd_limit_now = wd_limit(tsel_reg, clksel_reg);
	assign window_open = wd_limit_now - (wd_limit_now >> 2);
	assign wd_enabled = (tsel_reg != 2'h0); // RQ6
	assign window_active = win_reg & ~clksel_reg; // RQ16
	assign bad_byte = wr_cause & (hwdata[7:0] != SERVICE_FIRST)
		& (hwdata[7:0] != SERVICE_SECOND); // RQ9
	assign early = wr_cause & ~bad_byte & window_active & wd_enabled
		& (wd_count_reg < window_open); // RQ14 RQ15
	assign service_done = wr_cause & (hwdata[7:0] == SERVICE_SECOND) & armed_reg & ~early; // RQ7
	assign halt = debug_mode | stop_mode;
	assign tick = clksel_reg ? osc_edge : 1'b1; // RQ11
	assign wd_expire = wd_enabled & tick & ~halt & ~in_reset
		& (wd_count_reg == wd_limit_now - COUNT_WIDTH'(1)); // RQ10
	assign cfg_first = (wr_opt1 & ~lock1_reg) | (wr_opt2 & ~lock2_reg);

	// Every simultaneous source lands in the cause vector; debug reset has no bit
	assign req_vec[CAUSE_POR] = 1'b0;
	assign req_vec[CAUSE_VOLT] = src_sync_reg[0];
	assign req_vec[CAUSE_WDOG] = ~in_reset & (bad_byte | early | wd_expire);
	assign req_vec[CAUSE_OPCODE] = src_sync_reg[1];
	assign req_vec[CAUSE_PIN] = src_sync_reg[2];
	assign req_vec[CAUSE_CLOCK] = src_sync_reg[3];
	assign any_req = (|req_vec) | src_sync_reg[4]; // RQ5

	// First 0x55 arms the sequence; any other byte disarms it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_reg <= 1'b0;
		end else if (in_reset) begin
			armed_reg <= 1'b0;
		end else if (wr_cause) begin
			armed_reg <= (hwdata[7:0] == SERVICE_FIRST); // RQ7
		end
	end

	// ----------------------------------------------------------------
	// Write-once configuration
	// ----------------------------------------------------------------
	// Locks fall at every system reset so start-up code can fix settings again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tsel_reg <= TSEL_RESET;
			clksel_reg <= CLKSEL_RESET;
			win_reg <= WINDOW_RESET;
			lock1_reg <= 1'b0;
			lock2_reg <= 1'b0;
		end else if (in_reset) begin
			tsel_reg <= TSEL_RESET; // RQ13
			clksel_reg <= CLKSEL_RESET; // RQ13
			win_reg <= WINDOW_RESET;
			lock1_reg <= 1'b0;
			lock2_reg <= 1'b0;
		end else begin
			if (wr_opt1 && !lock1_reg) begin
				tsel_reg <= hwdata[OPT1_TSEL_LSB +: 2]; // RQ17
				lock1_reg <= 1'b1;
			end
			if (wr_opt2 && !lock2_reg) begin
				clksel_reg <= hwdata[OPT2_CLKSEL_BIT]; // RQ17
				win_reg <= hwdata[OPT2_WINDOW_BIT];
				lock2_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Watchdog counter
	// ----------------------------------------------------------------
	// Debug and stop hold the bus-clock count but wipe the oscillator count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_count_reg <= '0;
		end else if (in_reset || service_done || cfg_first) begin
			wd_count_reg <= '0; // RQ7 RQ17
		end else if (clksel_reg && halt) begin
			wd_count_reg <= '0; // RQ20
		end else if (wd_enabled && tick && !halt) begin
			wd_count_reg <= wd_expire ? '0 : wd_count_reg + COUNT_WIDTH'(1); // RQ19
		end
	end

	// ----------------------------------------------------------------
	// Reset sequencer and vector fetch
	// ----------------------------------------------------------------
	// A level source held active keeps restarting the hold count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_RESET;
			hold_cnt_reg <= 16'h0000;
			vec_addr_reg <= VECTOR_HI_ADDR;
		end else if (any_req) begin
			state_reg <= ST_RESET;
			hold_cnt_reg <= 16'h0000;
		end else begin
			unique case (state_reg)
				ST_RESET: begin
					if (hold_cnt_reg == 16'(RESET_HOLD - 1)) begin
						state_reg <= ST_VEC_HI;
						vec_addr_reg <= VECTOR_HI_ADDR; // RQ1
					end else begin
						hold_cnt_reg <= hold_cnt_reg + 16'h0001;
					end
				end
				ST_VEC_HI: begin
					state_reg <= ST_VEC_LO;
					vec_addr_reg <= VECTOR_LO_ADDR; // RQ1
				end
				ST_VEC_LO: state_reg <= ST_VEC_END;
				ST_VEC_END: state_reg <= ST_RUN;
				ST_RUN: state_reg <= ST_RUN;
			endcase
		end
	end

	// Memory answers one cycle after the read strobe; high byte comes first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_init_reg <= 16'h0000;
		end else if (state_reg == ST_VEC_LO) begin
			pc_init_reg[15:8] <= vec_data; // RQ1
		end else if (state_reg == ST_VEC_END) begin
			pc_init_reg[7:0] <= vec_data; // RQ1
		end
	end

	// Latest reset overwrites the whole cause vector; writes never touch it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_reg <= CAUSE_RESET; // RQ5
		end else if (any_req) begin
			cause_reg <= req_vec; // RQ22 RQ8
		end
	end

	// ----------------------------------------------------------------
	// Processor and pin outputs
	// ----------------------------------------------------------------
	assign in_reset = (state_reg == ST_RESET);
	assign vec_addr = vec_addr_reg;
	assign vec_rd = (state_reg == ST_VEC_HI) | (state_reg == ST_VEC_LO); // RQ1
	assign pc_init = pc_init_reg;
	assign cpu_run = (state_reg == ST_RUN);
	assign stack_pointer_init = STACK_POINTER_INIT; // RQ2
	assign irq_mask_set = ~cpu_run; // RQ4
	assign periph_enable = cpu_run; // RQ3
	assign pin_out_en = cpu_run ? port_out_en_req : '0; // RQ3
	assign pin_pullup_en = cpu_run ? port_pullup_req : '0; // RQ3
	assign reset_cause = cause_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_bad_byte_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
		(bad_byte && !in_reset) |=> (in_reset && cause_reg[CAUSE_WDOG]))
		else $error("bad service byte did not reset");

	a_expire_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
		wd_expire |=> (in_reset && cause_reg[CAUSE_WDOG] && wd_count_reg == '0))
		else $error("watchdog expiry did not reset");

	a_early_window: assert property (@(posedge hclk) disable iff (!hresetn) // RQ15
		(early && !in_reset) |=> in_reset)
		else $error("early window service did not reset");

	a_window_osc: assert property (@(posedge hclk) disable iff (!hresetn) // RQ16
		clksel_reg |-> !early)
		else $error("window applied with oscillator clock");

	a_service_restart: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
		(wr_cause && armed_reg && hwdata[7:0] == SERVICE_SECOND && !early && !in_reset)
		|=> wd_count_reg == '0)
		else $error("service pair did not restart count");

	a_cause_readonly: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
		(wr_cause && !any_req) |=> $stable(cause_reg))
		else $error("cause bits changed by a write");

	a_write_once: assert property (@(posedge hclk) disable iff (!hresetn) // RQ17
		(wr_opt1 && lock1_reg && !any_req && !in_reset) |=> $stable(tsel_reg))
		else $error("locked option register changed");

	a_bus_halt_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RQ19
		(!clksel_reg && halt && !in_reset && !service_done && !cfg_first)
		|=> $stable(wd_count_reg))
		else $error("bus clock count moved while halted");

	a_osc_halt_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RQ20
		(clksel_reg && halt) |=> wd_count_reg == '0)
		else $error("oscillator count not cleared while halted");

	a_reset_safe: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
		in_reset |-> (pin_out_en == '0 && pin_pullup_en == '0 && !periph_enable
		&& irq_mask_set))
		else $error("pins or mask not safe in reset");

	a_vector_fetch: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
		(state_reg == ST_VEC_END && !any_req) |=> (cpu_run
		&& pc_init == {$past(vec_data, 2), $past(vec_data)}))
		else $error("program counter not loaded from vector");

	a_default_config: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
		in_reset |=> (tsel_reg == TSEL_RESET && clksel_reg == CLKSEL_RESET && !lock1_reg))
		else $error("watchdog default not restored by reset");

endmodule

// ==== srwd_top_tb.sv ====
// Self-checking testbench for the system reset and watchdog block
`timescale 1ns/1ps
module srwd_top_tb;
	import srwd_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus, responses and bench state
	// ----------------------------------------------------------------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [4:0] src = 5'h00; // Bits: voltage, opcode, pin, clock loss, debug
	logic [2:0] osc_div = 3'h0;
	logic debug_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic [15:0] vec_addr;
	logic vec_rd;
	logic [7:0] vec_data = 8'h00;
	logic [7:0] vec_hi = 8'hC3;
	logic [7:0] vec_lo = 8'h5A;
	logic [15:0] pc_init;
	logic cpu_run;
	logic [15:0] stack_pointer_init;
	logic irq_mask_set;
	logic periph_enable;
	logic [7:0] out_req = 8'hA5;
	logic [7:0] pull_req = 8'h3C;
	logic [7:0] pin_out_en;
	logic [7:0] pin_pullup_en;
	logic [5:0] reset_cause;
	logic [31:0] seed = 32'h0000DFBC;
	logic [31:0] c1;
	logic [31:0] c2;
	int err_total = 0;
	int n_compared = 0;
	int k;
	int lim[4] = '{0, 16, 32, 64};
	logic [5:0] cause_exp[5] = '{6'h02, 6'h08, 6'h10, 6'h20, 6'h00};

	// Bus watchdog counts are shortened so every bus clock bite fits in a few hundred cycles
	srwd_top #(.BUS_TIMEOUT_1(16), .BUS_TIMEOUT_2(32), .BUS_TIMEOUT_3(64), .RESET_HOLD(2),
		.PIN_COUNT(8)) i_srwd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .low_voltage_detect(src[0]),
		.illegal_opcode_detect(src[1]), .ext_reset_pin_n(~src[2]), .clock_loss_reset(src[3]),
		.debug_force_reset(src[4]), .low_power_oscillator(osc_div[2]), .debug_mode(debug_mode),
		.stop_mode(stop_mode), .vec_addr(vec_addr), .vec_rd(vec_rd), .vec_data(vec_data),
		.pc_init(pc_init), .cpu_run(cpu_run), .stack_pointer_init(stack_pointer_init),
		.irq_mask_set(irq_mask_set), .periph_enable(periph_enable), .port_out_en_req(out_req),
		.port_pullup_req(pull_req), .pin_out_en(pin_out_en), .pin_pullup_en(pin_pullup_en),
		.reset_cause(reset_cause));

	// ----------------------------------------------------------------
	// Clock, oscillator stand-in and vector memory
	// ----------------------------------------------------------------
	always #2.5 hclk = ~hclk;

	// Oscillator runs free at one eighth of the bus clock, fast enough to bite quickly
	always @(posedge hclk) begin
		osc_div <= osc_div + 3'h1;
	end

	// Registered memory: data follows the address one cycle later; unread it shows junk
	always @(posedge hclk) begin
		vec_data <= !vec_rd ? ~vec_lo : (vec_addr == VECTOR_HI_ADDR) ? vec_hi : vec_lo;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic test_done();
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Waits for the next edge with ready high; a stuck bus ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				err_total++;
				test_done();
			end
			@(posedge hclk);
		end
	endtask

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(what, exp, q);
	endtask

	task automatic wait_run(input logic lv, input int lim_n);
		int n;
		n = 0;
		while (cpu_run !== lv) begin
			n++;
			if (n > lim_n) begin
				err_total++;
				test_done();
			end
			@(posedge hclk);
			#1;
		end
	endtask

	// Follows one reset to the running state and checks what it leaves behind
	task automatic restart(input logic [5:0] cause, input int fall_n);
		logic [31:0] r;
		wait_run(1'b0, fall_n);
		chk("pins_in_reset", 32'h0, 32'({pin_out_en, pin_pullup_en, periph_enable}));
		chk("imask", 32'h1, 32'(irq_mask_set));
		wait_run(1'b1, 100);
		chk("pc", 32'({vec_hi, vec_lo}), 32'(pc_init));
		chk("sp", 32'h00FF, 32'(stack_pointer_init));
		chk("resp", 32'h0, 32'(hresp));
		chk("pins_run", 32'({out_req, pull_req, 1'b1, 1'b0}),
			32'({pin_out_en, pin_pullup_en, periph_enable, irq_mask_set}));
		chk("cause_port", 32'(cause), 32'(reset_cause));
		rd("cause", ADDR_CAUSE, 32'(cause));
		r = xs();
		out_req <= r[7:0];
		pull_req <= r[15:8];
		vec_hi <= r[23:16];
		vec_lo <= r[31:24];
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		cyc(2);
		hresetn <= 1'b1;
		restart(CAUSE_RESET, 4);
		// Defaults: oscillator clock, longest timeout, no lock
		rd("opt1_dflt", ADDR_OPT_ONE, 32'h003);
		rd("opt2_dflt", ADDR_OPT_TWO, 32'h001);
		rd("unmapped", 8'h10, 32'h0);
		bus(1'b0, ADDR_COUNT, 32'h0, c1);
		cyc(40);
		bus(1'b0, ADDR_COUNT, 32'h0, c2);
		chk("osc_rate", 32'h1, 32'((c2 - c1) inside {[4:7]}));
		// Window bit is ignored on the oscillator, so an instant service is accepted
		wr(ADDR_OPT_TWO, 32'h3);
		wr(ADDR_OPT_ONE, 32'h1);
		wr(ADDR_CAUSE, 32'h55);
		wr(ADDR_CAUSE, 32'hAA);
		wr(ADDR_OPT_ONE, 32'h2);
		rd("opt1_lock", ADDR_OPT_ONE, 32'h101);
		rd("opt2_lock", ADDR_OPT_TWO, 32'h103);
		chk("osc_window", 32'h1, 32'(cpu_run));
		stop_mode <= 1'b1;
		cyc(20);
		bus(1'b0, ADDR_COUNT, 32'h0, c1);
		chk("osc_halt", 32'h0, c1);
		stop_mode <= 1'b0;
		wr(ADDR_CAUSE, 32'h33);
		restart(6'h04, 4);
		// Bite time for every bus clock timeout length
		for (int t = 1; t < 4; t++) begin
			wr(ADDR_OPT_ONE, 32'(t));
			wr(ADDR_OPT_TWO, 32'h0);
			k = 0;
			while (cpu_run === 1'b1 && k < 200) begin
				@(posedge hclk);
				#1;
				k++;
			end
			chk("bite_time", 32'h1, 32'(k >= lim[t] - 2 && k <= lim[t] + 4));
			restart(6'h04, 4);
		end
		// Bus clock: count holds in debug mode, service restarts it
		wr(ADDR_OPT_ONE, 32'h3);
		wr(ADDR_OPT_TWO, 32'h0);
		cyc(10);
		debug_mode <= 1'b1;
		bus(1'b0, ADDR_COUNT, 32'h0, c1);
		cyc(10);
		bus(1'b0, ADDR_COUNT, 32'h0, c2);
		chk("bus_hold", c1, c2);
		debug_mode <= 1'b0;
		cyc(20);
		bus(1'b0, ADDR_COUNT, 32'h0, c1);
		chk("bus_resume", 32'h1, 32'((c1 - c2) inside {[20:26]}));
		wr(ADDR_CAUSE, 32'h55);
		wr(ADDR_CAUSE, 32'hAA);
		bus(1'b0, ADDR_COUNT, 32'h0, c1);
		chk("serviced", 32'h1, 32'(c1 < 4));
		rd("cause_kept", ADDR_CAUSE, 32'h04);
		cyc(50);
		chk("no_early_bite", 32'h1, 32'(cpu_run));
		restart(6'h04, 20);
		// Window mode: late service is accepted, early service bites
		wr(ADDR_OPT_ONE, 32'h3);
		wr(ADDR_OPT_TWO, 32'h2);
		cyc(52);
		wr(ADDR_CAUSE, 32'h55);
		wr(ADDR_CAUSE, 32'hAA);
		bus(1'b0, ADDR_COUNT, 32'h0, c1);
		chk("window_ok", 32'h1, 32'(cpu_run === 1'b1 && c1 < 4));
		cyc(20);
		wr(ADDR_CAUSE, 32'h55);
		restart(6'h04, 4);
		// Timeout select zero switches the watchdog off
		wr(ADDR_OPT_ONE, 32'h0);
		wr(ADDR_OPT_TWO, 32'h0);
		cyc(150);
		chk("disabled", 32'h1, 32'(cpu_run));
		// Each outside source in turn; debug force leaves no cause bit
		for (int i = 0; i < 5; i++) begin
			src <= 5'(1 << i);
			cyc(4);
			src <= 5'h00;
			restart(cause_exp[i], 10);
		end
		// Power-on reset in mid-run
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		restart(CAUSE_RESET, 4);
		// Default oscillator timeout: 1024 ticks of eight bus cycles each
		k = 0;
		while (cpu_run === 1'b1 && k < 9000) begin
			@(posedge hclk);
			#1;
			k++;
		end
		chk("osc_bite", 32'h1, 32'(k >= 8100 && k <= 8250));
		restart(6'h04, 4);
		test_done();
	end
endmodule
